// ==== core/tei_ctrl.sv ====
// Purpose: Timer and external interrupt gating with entry/return sequencing
// Assumes: APB slave; timer events are one-cycle pulses on pclk
// Notes:   Core handshake abstracted to instr_boundary and return_from_irq_instr
//
// Summary of operation
// - Timer irq taken only when enable, global enable and flag are all set.
// - Timer-2 compare vectors to 003, timer-2 overflow to 004.
// - Timer-1 capture vectors to 005, timer-1 compare A to 006.
// - Timer-1 compare B to 007, timer-1 overflow 008, timer-0 overflow 009.
// - Timer-2 compare match sets flag bit 7.
// - Timer-2 overflow sets flag bit 6.
// - Capture into capture register sets flag bit 5.
// - Timer-1 compare A sets bit 4, compare B sets bit 3.
// - Timer-1 overflow, or up/down PWM leaving zero, sets bit 2.
// - Timer-0 overflow sets flag bit 0.
// - Vectoring clears the flag of the serviced source.
// - Writing one to a flag bit clears exactly that flag.
// - Bit 1 of enables and flags is reserved and reads zero.
// - External pins request even when configured as outputs.
// - Each external pin triggers on falling edge, rising edge or low level.
// - Low-level external request persists while the pin stays low.
// - Handler vector executes no sooner than four cycles after flag set.
// - Entry pushes two-byte program counter, stack pointer drops by two.
// - A multi-cycle instruction finishes before interrupt entry starts.
// - Return takes four cycles, pops counter, stack up two, sets global enable.
// - After return one main-program instruction runs before next interrupt.
// - Sense field: 00 low level, 10 falling, 11 rising, 01 reserved.
// - Accepting an interrupt clears the global enable bit.
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module tei_ctrl
    import tei_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Timer event pulses
    input  wire logic        t2_compare_evt,
    input  wire logic        t2_overflow_evt,
    input  wire logic        t1_capture_evt,
    input  wire logic        t1_compare_a_evt,
    input  wire logic        t1_compare_b_evt,
    input  wire logic        t1_overflow_evt,
    input  wire logic        t1_updown_leave_zero_evt,
    input  wire logic        t0_overflow_evt,
    // External pins
    input  wire logic        ext_irq_pin_zero,
    input  wire logic        ext_irq_pin_one,
    // Core sequencer side
    input  wire logic        instr_boundary,
    input  wire logic        return_from_irq_instr,
    input  wire logic [15:0] pc_current,
    output logic             irq_entry_busy,
    output logic             irq_return_busy,
    output logic             vector_valid,
    output logic      [7:0]  vector_addr,
    output logic      [15:0] stack_pointer,
    output logic      [15:0] pc_saved,
    output logic             global_irq_enable
);
    logic [7:0]    flags_reg;
    logic [7:0]    enables_reg;
    logic [7:0]    core_status_reg;
    logic [7:0]    core_control_reg;
    logic [7:0]    ext_ctrl_reg;
    logic [15:0]   sp_reg;
    logic [15:0]   pc_saved_reg;
    logic [2:0]    cnt_reg;
    logic [7:0]    vec_reg;
    logic          vec_valid_reg;
    logic [31:0]   prdata_reg;
    logic          pready_reg;
    logic          pslverr_reg;
    logic [1:0]    pin0_sync_reg;
    logic [1:0]    pin1_sync_reg;
    tei_state_type state_reg;
    tei_state_type state_next;

    logic [7:0]    flag_set;
    logic [7:0]    flag_wclr;
    logic [7:0]    flag_vclr;
    logic [7:0]    pending;
    logic          ext0_req;
    logic          ext1_req;
    logic          any_req;
    logic [7:0]    win_vec;
    logic [7:0]    win_mask;
    logic          ext0_vclr;
    logic          ext1_vclr;
    logic          wr;
    logic          take;

    tei_ext_if ext0 ();
    tei_ext_if ext1 ();

    // Pins leave the clock domain; two flops each before any use
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pin0_sync_reg <= 2'h3;
            pin1_sync_reg <= 2'h3;
        end
        else
        begin
            pin0_sync_reg <= {pin0_sync_reg[0], ext_irq_pin_zero};
            pin1_sync_reg <= {pin1_sync_reg[0], ext_irq_pin_one};
        end
    end

    assign wr = psel & penable & pwrite;

    assign ext0.pin_sync     = pin0_sync_reg[1];
    assign ext0.sense        = core_control_reg[1:0];
    assign ext0.vector_clear = ext0_vclr;
    assign ext0.write_clear  = 1'b0;
    assign ext1.pin_sync     = pin1_sync_reg[1];
    assign ext1.sense        = core_control_reg[3:2];
    assign ext1.vector_clear = ext1_vclr;
    assign ext1.write_clear  = 1'b0;

    tei_ext_sense u_ext0
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ext     (ext0.sense_unit)
    );
    tei_ext_sense u_ext1
    (
        .pclk    (pclk),
        .presetn (presetn),
        .ext     (ext1.sense_unit)
    );

    always_comb
    begin
        flag_set = 8'h00;
        flag_set[T2_CMP_BIT]  = t2_compare_evt;
        flag_set[T2_OVF_BIT]  = t2_overflow_evt;
        flag_set[T1_CAP_BIT]  = t1_capture_evt;
        flag_set[T1_CMPA_BIT] = t1_compare_a_evt;
        flag_set[T1_CMPB_BIT] = t1_compare_b_evt;
        flag_set[T1_OVF_BIT]  = t1_overflow_evt | t1_updown_leave_zero_evt;
        flag_set[T0_OVF_BIT]  = t0_overflow_evt;
    end

    assign flag_wclr = (wr && paddr == FLAGS_ADDR) ? pwdata[7:0] : 8'h00;
    assign pending   = flags_reg & enables_reg & TIMER_BIT_MASK;
    assign ext0_req  = ext0.request & ext_ctrl_reg[EXT0_EN_BIT];
    assign ext1_req  = ext1.request & ext_ctrl_reg[EXT1_EN_BIT];
    assign any_req   = core_status_reg[GIE_BIT] & (ext0_req | ext1_req | (|pending));

    // Fixed priority by vector address, lowest first
    always_comb
    begin
        win_vec  = 8'h00;
        win_mask = 8'h00;
        if (ext0_req)
            win_vec = VEC_EXT0;
        else if (ext1_req)
            win_vec = VEC_EXT1;
        else if (pending[T2_CMP_BIT])
        begin
            win_vec = VEC_T2_CMP;
            win_mask[T2_CMP_BIT] = 1'b1;
        end
        else if (pending[T2_OVF_BIT])
        begin
            win_vec = VEC_T2_OVF;
            win_mask[T2_OVF_BIT] = 1'b1;
        end
        else if (pending[T1_CAP_BIT])
        begin
            win_vec = VEC_T1_CAP;
            win_mask[T1_CAP_BIT] = 1'b1;
        end
        else if (pending[T1_CMPA_BIT])
        begin
            win_vec = VEC_T1_CMPA;
            win_mask[T1_CMPA_BIT] = 1'b1;
        end
        else if (pending[T1_CMPB_BIT])
        begin
            win_vec = VEC_T1_CMPB;
            win_mask[T1_CMPB_BIT] = 1'b1;
        end
        else if (pending[T1_OVF_BIT])
        begin
            win_vec = VEC_T1_OVF;
            win_mask[T1_OVF_BIT] = 1'b1;
        end
        else if (pending[T0_OVF_BIT])
        begin
            win_vec = VEC_T0_OVF;
            win_mask[T0_OVF_BIT] = 1'b1;
        end
    end

    // Winner latched at acceptance; flags may move during entry
    assign take      = (state_reg == ST_RUN) && instr_boundary && any_req;
    assign flag_vclr = (take) ? win_mask : 8'h00;
    assign ext0_vclr = take && (win_vec == VEC_EXT0);
    assign ext1_vclr = take && (win_vec == VEC_EXT1);

    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_RUN:
                if (take)
                    state_next = ST_ENTRY;
                else if (instr_boundary && return_from_irq_instr)
                    state_next = ST_RETURN;
            ST_ENTRY:
                if (cnt_reg == ENTRY_CYCLES - 3'h1)
                    state_next = ST_RUN;
            ST_RETURN:
                if (cnt_reg == RETURN_CYCLES - 3'h1)
                    state_next = ST_SHADOW;
            ST_SHADOW:
                if (instr_boundary)
                    state_next = ST_RUN;
            default:
                state_next = ST_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg       <= ST_RUN;
            irq_entry_busy  <= 1'b0;
            irq_return_busy <= 1'b0;
        end
        else
        begin
            state_reg       <= state_next;
            irq_entry_busy  <= (state_next == ST_ENTRY);
            irq_return_busy <= (state_next == ST_RETURN);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cnt_reg <= 3'h0;
        else if (state_next != state_reg)
            cnt_reg <= 3'h0;
        else if (state_reg == ST_ENTRY || state_reg == ST_RETURN)
            cnt_reg <= cnt_reg + 3'h1;
    end

    // Stack moves once per entry or return, counter saved at acceptance
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sp_reg       <= SP_RESET;
            pc_saved_reg <= SP_RESET;
        end
        else if (take)
        begin
            sp_reg       <= sp_reg - SP_STEP;
            pc_saved_reg <= pc_current;
        end
        else if (state_reg == ST_RUN && instr_boundary && return_from_irq_instr)
            sp_reg <= sp_reg + SP_STEP;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_reg       <= REG_RESET;
            vec_valid_reg <= 1'b0;
        end
        else
        begin
            if (take)
                vec_reg <= win_vec;
            vec_valid_reg <= (state_reg == ST_ENTRY) && (state_next == ST_RUN);
        end
    end

    // Hardware events beat software clears in the same cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            flags_reg <= REG_RESET;
        else
            flags_reg <= (flag_set | (flags_reg & ~(flag_wclr | flag_vclr))) & TIMER_BIT_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            enables_reg <= REG_RESET;
        else if (wr && paddr == ENABLES_ADDR)
            enables_reg <= pwdata[7:0] & TIMER_BIT_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            core_status_reg <= REG_RESET;
        else if (take)
            core_status_reg[GIE_BIT] <= 1'b0;
        else if (state_reg == ST_RETURN && state_next == ST_SHADOW)
            core_status_reg[GIE_BIT] <= 1'b1;
        else if (wr && paddr == CORE_STATUS_ADDR)
            core_status_reg <= pwdata[7:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            core_control_reg <= REG_RESET;
            ext_ctrl_reg     <= REG_RESET;
        end
        else
        begin
            if (wr && paddr == CONTROL_ADDR)
                core_control_reg <= {1'b0, pwdata[6:0]};
            if (wr && paddr == EXT_CTRL_ADDR)
                ext_ctrl_reg <= {pwdata[7:6], 6'h00};
        end
    end

    // Zero-wait slave: ready in every access cycle, error on unmapped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= psel & ~penable;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            if (psel && !penable)
            begin
                unique case (paddr)
                    FLAGS_ADDR:       prdata_reg <= {24'h000000, flags_reg};
                    ENABLES_ADDR:     prdata_reg <= {24'h000000, enables_reg};
                    CORE_STATUS_ADDR: prdata_reg <= {24'h000000, core_status_reg};
                    CONTROL_ADDR:     prdata_reg <= {24'h000000, core_control_reg};
                    EXT_CTRL_ADDR:    prdata_reg <= {24'h000000, ext_ctrl_reg};
                    default:          pslverr_reg <= 1'b1;
                endcase
            end
        end
    end

    assign prdata            = prdata_reg;
    assign pready            = pready_reg;
    assign pslverr           = pslverr_reg;
    assign vector_valid      = vec_valid_reg;
    assign vector_addr       = vec_reg;
    assign stack_pointer     = sp_reg;
    assign pc_saved          = pc_saved_reg;
    assign global_irq_enable = core_status_reg[GIE_BIT];
endmodule : tei_ctrl

// ==== core/tei_pkg.sv ====
// Purpose: Shared constants for the timer/external interrupt controller
// Assumes: 8-bit registers on a 32-bit APB word, one aligned word each
// Notes:   Register indices kept as printed; byte address is four times the index
package tei_pkg;
    localparam logic [7:0]  FLAGS_IDX        = 8'h38;
    localparam logic [7:0]  ENABLES_IDX      = 8'h39;
    localparam logic [7:0]  CONTROL_IDX      = 8'h3A;
    localparam logic [7:0]  CORE_STATUS_IDX  = 8'h3B;
    localparam logic [7:0]  EXT_CTRL_IDX     = 8'h3C;
    localparam logic [11:0] FLAGS_ADDR       = {2'h0, FLAGS_IDX, 2'h0};
    localparam logic [11:0] ENABLES_ADDR     = {2'h0, ENABLES_IDX, 2'h0};
    localparam logic [11:0] CONTROL_ADDR     = {2'h0, CONTROL_IDX, 2'h0};
    localparam logic [11:0] CORE_STATUS_ADDR = {2'h0, CORE_STATUS_IDX, 2'h0};
    localparam logic [11:0] EXT_CTRL_ADDR    = {2'h0, EXT_CTRL_IDX, 2'h0};
    localparam logic [7:0]  REG_RESET        = 8'h00;
    localparam logic [7:0]  TIMER_BIT_MASK   = 8'hFD;
    localparam int          T2_CMP_BIT       = 7;
    localparam int          T2_OVF_BIT       = 6;
    localparam int          T1_CAP_BIT       = 5;
    localparam int          T1_CMPA_BIT      = 4;
    localparam int          T1_CMPB_BIT      = 3;
    localparam int          T1_OVF_BIT       = 2;
    localparam int          T0_OVF_BIT       = 0;
    localparam int          GIE_BIT          = 7;
    localparam int          EXT0_EN_BIT      = 6;
    localparam int          EXT1_EN_BIT      = 7;
    localparam logic [7:0]  VEC_EXT0         = 8'h01;
    localparam logic [7:0]  VEC_EXT1         = 8'h02;
    localparam logic [7:0]  VEC_T2_CMP       = 8'h03;
    localparam logic [7:0]  VEC_T2_OVF       = 8'h04;
    localparam logic [7:0]  VEC_T1_CAP       = 8'h05;
    localparam logic [7:0]  VEC_T1_CMPA      = 8'h06;
    localparam logic [7:0]  VEC_T1_CMPB      = 8'h07;
    localparam logic [7:0]  VEC_T1_OVF       = 8'h08;
    localparam logic [7:0]  VEC_T0_OVF       = 8'h09;
    localparam logic [1:0]  SENSE_LOW        = 2'h0;
    localparam logic [1:0]  SENSE_RSVD       = 2'h1;
    localparam logic [1:0]  SENSE_FALL       = 2'h2;
    localparam logic [1:0]  SENSE_RISE       = 2'h3;
    localparam int          ENTRY_NS         = 40;
    localparam int          RETURN_NS        = 40;
    localparam int          CLK_PERIOD_NS    = 10;
    localparam logic [2:0]  ENTRY_CYCLES     = 3'((ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [2:0]  RETURN_CYCLES    = 3'((RETURN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [15:0] SP_STEP          = 16'h0002;
    localparam logic [15:0] SP_RESET         = 16'h0000;

    typedef enum logic [2:0]
    {
        ST_RUN    = 3'b000,
        ST_ENTRY  = 3'b001,
        ST_RETURN = 3'b010,
        ST_SHADOW = 3'b011
    } tei_state_type;
endpackage : tei_pkg

// ==== core/tei_ext_if.sv ====
// Purpose: Carrier between the top and the external pin sense unit
// Assumes: One clock, pins already synchronised by the top
// Notes:   Request is a level for low-level sensing, sticky for edges
`timescale 1ns/1ps
interface tei_ext_if;
    logic       pin_sync;
    logic [1:0] sense;
    logic       vector_clear;
    logic       write_clear;
    logic       request;

    modport top
    (
        output pin_sync,
        output sense,
        output vector_clear,
        output write_clear,
        input  request
    );
    modport sense_unit
    (
        input  pin_sync,
        input  sense,
        input  vector_clear,
        input  write_clear,
        output request
    );
endinterface : tei_ext_if

// ==== core/tei_ext_sense.sv ====
// Purpose: Edge or level detection for one external interrupt pin
// Assumes: Pin input is already two-flop synchronised
// Notes:   Pin driven as output still reaches here, giving a software interrupt
`timescale 1ns/1ps
module tei_ext_sense
    import tei_pkg::*;
(
    // Clock and reset
    input wire logic       pclk,
    input wire logic       presetn,
    // Link to top
    tei_ext_if.sense_unit  ext
);
    logic prev_reg;
    logic edge_flag_reg;
    logic edge_hit;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_reg <= 1'b1;
        else
            prev_reg <= ext.pin_sync;
    end

    always_comb
    begin
        edge_hit = 1'b0;
        unique case (ext.sense)
            SENSE_FALL: edge_hit = prev_reg & ~ext.pin_sync;
            SENSE_RISE: edge_hit = ~prev_reg & ext.pin_sync;
            SENSE_LOW:  edge_hit = 1'b0;
            SENSE_RSVD: edge_hit = 1'b0;
        endcase
    end

    // Set wins over clear so a fresh edge is never lost
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            edge_flag_reg <= 1'b0;
        else if (ext.sense == SENSE_LOW || ext.sense == SENSE_RSVD)
            edge_flag_reg <= 1'b0;
        else if (edge_hit)
            edge_flag_reg <= 1'b1;
        else if (ext.vector_clear || ext.write_clear)
            edge_flag_reg <= 1'b0;
    end

    // Level request holds only while the pin is low; no memory
    assign ext.request = (ext.sense == SENSE_LOW) ? ~ext.pin_sync : edge_flag_reg;
endmodule : tei_ext_sense

// ==== verification/tei_ctrl_checker.sv ====
// Purpose: Port-level assertions for the interrupt controller
// Assumes: One pclk domain, presetn async active low
// Notes:   Entry and return spans are four cycles each
`timescale 1ns/1ps
module tei_ctrl_checker
    import tei_pkg::*;
(
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    // Core side
    input wire logic        instr_boundary,
    input wire logic [15:0] pc_current,
    input wire logic        irq_entry_busy,
    input wire logic        irq_return_busy,
    input wire logic        vector_valid,
    input wire logic [15:0] stack_pointer,
    input wire logic [15:0] pc_saved,
    input wire logic        global_irq_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence take_s; $rose(irq_entry_busy); endsequence
    sequence ret_s; $rose(irq_return_busy); endsequence

    entry_span_a: assert property (
        take_s |-> irq_entry_busy[*4] ##1 !irq_entry_busy) else $error("entry span wrong");
    vector_time_a: assert property (take_s |-> ##4 vector_valid)
        else $error("vector pulse misplaced");
    gie_clear_a: assert property (take_s |-> !global_irq_enable)
        else $error("global enable kept on entry");
    take_cause_a: assert property (
        take_s |-> $past(instr_boundary) && $past(global_irq_enable)) else $error("bad take");
    sp_push_a: assert property (
        take_s |-> stack_pointer == $past(stack_pointer) - SP_STEP) else $error("push wrong");
    pc_push_a: assert property (take_s |-> pc_saved == $past(pc_current))
        else $error("saved counter wrong");
    sp_pop_a: assert property (
        ret_s |-> stack_pointer == $past(stack_pointer) + SP_STEP) else $error("pop wrong");
    ret_span_a: assert property (ret_s |-> irq_return_busy[*4] ##1
        !irq_return_busy ##[0:1] global_irq_enable) else $error("return span wrong");
    shadow_a: assert property ($fell(irq_return_busy) |-> !irq_entry_busy[*2])
        else $error("no instruction after return");
    rsvd_zero_a: assert property (pready && !pwrite &&
        (paddr == FLAGS_ADDR || paddr == ENABLES_ADDR) |-> prdata[1] == 1'b0 &&
        prdata[31:8] == 24'h000000) else $error("reserved bits not zero");

    cover property (take_s);
    cover property (ret_s);
    cover property ($fell(irq_return_busy) ##[1:20] take_s);
endmodule : tei_ctrl_checker

bind tei_ctrl tei_ctrl_checker i_chk
(
    .pclk, .presetn, .pwrite, .paddr, .prdata, .pready, .instr_boundary, .pc_current,
    .irq_entry_busy, .irq_return_busy, .vector_valid, .stack_pointer, .pc_saved,
    .global_irq_enable
);

// ==== verification/tei_core_model.sv ====
// Purpose: Core sequencer stand-in ending instructions and returns
// Assumes: Sequencer stalls while entry or return is busy
// Notes:   Slow mode makes every instruction three cycles long
`timescale 1ns/1ps
module tei_core_model
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench control
    input  wire logic        slow_mode,
    input  wire logic        ret_req,
    // Controller side
    input  wire logic        irq_entry_busy,
    input  wire logic        irq_return_busy,
    output logic             instr_boundary,
    output logic             return_from_irq_instr,
    output logic      [15:0] pc_current
);
    logic [1:0] cyc_reg;
    logic       busy;
    assign busy = irq_entry_busy | irq_return_busy;
    // Multi-cycle instruction ends only on its last cycle
    assign instr_boundary        = !busy && (cyc_reg == (slow_mode ? 2'h2 : 2'h0));
    assign return_from_irq_instr = instr_boundary & ret_req;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_reg <= 2'h0;
        else if (instr_boundary || busy)
            cyc_reg <= 2'h0;
        else
            cyc_reg <= cyc_reg + 2'h1;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pc_current <= 16'h0100;
        else if (instr_boundary)
            pc_current <= pc_current + 16'h0001;
    end
endmodule : tei_core_model

// ==== verification/tb.sv ====
// Purpose: Self-checking bench for the interrupt controller
// Assumes: Core model ends instructions, bench pulses timer events
// Notes:   Pins idle high; each vector served then returned
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t %h %h", $time, a, b); end end
module tb;
    import tei_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0]  evt, vector_addr;
    logic        pin0, pin1, slow_mode, ret_req, instr_boundary, return_from_irq_instr;
    logic        irq_entry_busy, irq_return_busy, vector_valid, global_irq_enable;
    logic [15:0] pc_current, stack_pointer, pc_saved;
    int          n_mismatch = 0, compares = 0, cycles = 0;

    tei_ctrl i_dut
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .t2_compare_evt(evt[7]), .t2_overflow_evt(evt[6]), .t1_capture_evt(evt[5]),
        .t1_compare_a_evt(evt[4]), .t1_compare_b_evt(evt[3]), .t1_overflow_evt(evt[2]),
        .t1_updown_leave_zero_evt(evt[1]), .t0_overflow_evt(evt[0]),
        .ext_irq_pin_zero(pin0), .ext_irq_pin_one(pin1), .instr_boundary,
        .return_from_irq_instr, .pc_current, .irq_entry_busy, .irq_return_busy,
        .vector_valid, .vector_addr, .stack_pointer, .pc_saved, .global_irq_enable
    );
    tei_core_model i_core
    (
        .pclk, .presetn, .slow_mode, .ret_req, .irq_entry_busy, .irq_return_busy,
        .instr_boundary, .return_from_irq_instr, .pc_current
    );

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q       = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic pulse(input logic [7:0] v);
        @(posedge pclk);
        evt <= v;
        @(posedge pclk);
        evt <= 8'h00;
    endtask : pulse

    task automatic wait_vec(input logic [7:0] exp);
        int n;
        n = 0;
        do
        begin
            @(negedge pclk);
            n++;
        end
        while (vector_valid !== 1'b1 && n < 100);
        `CHK(vector_valid, 1'b1)
        `CHK(vector_addr, exp)
    endtask : wait_vec

    task automatic do_ret();
        @(posedge pclk);
        ret_req <= 1'b1;
        while (irq_return_busy !== 1'b1) @(negedge pclk);
        @(posedge pclk);
        ret_req <= 1'b0;
        while (irq_return_busy === 1'b1) @(negedge pclk);
        @(negedge pclk);
        `CHK(global_irq_enable, 1'b1)
    endtask : do_ret

    task automatic t_regs();
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h00000000)
        apb(1'b1, ENABLES_ADDR, 32'hFFFFFFFF);
        apb(1'b0, ENABLES_ADDR, 32'h00000000);
        `CHK(q, 32'h000000FD)
        apb(1'b0, 12'h100, 32'h00000000);
        `CHK(err, 1'b1)
    endtask : t_regs

    task automatic t_flags();
        pulse(8'hFB);
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h000000FD)
        apb(1'b1, FLAGS_ADDR, 32'h00000005);
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h000000F8)
        pulse(8'h02);
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h000000FC)
        apb(1'b1, FLAGS_ADDR, 32'h00000004);
        pulse(8'h04);
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h000000FC)
    endtask : t_flags

    task automatic t_vec();
        pulse(8'h01);
        slow_mode <= 1'b1;
        repeat (20) @(negedge pclk);
        `CHK(stack_pointer, 16'h0000)
        apb(1'b1, CORE_STATUS_ADDR, 32'h00000080);
        for (int i = 3; i <= 9; i++)
        begin
            wait_vec(8'(i));
            do_ret();
        end
        apb(1'b0, FLAGS_ADDR, 32'h00000000);
        `CHK(q, 32'h00000000)
    endtask : t_vec

    task automatic t_ext();
        slow_mode <= 1'b0;
        apb(1'b1, CONTROL_ADDR, 32'h0000000D);
        apb(1'b1, EXT_CTRL_ADDR, 32'h000000C0);
        pin0 <= 1'b0;
        pin1 <= 1'b0;
        repeat (20) @(negedge pclk);
        `CHK(global_irq_enable, 1'b1)
        @(posedge pclk);
        pin1 <= 1'b1;
        pin0 <= 1'b1;
        wait_vec(VEC_EXT1);
        do_ret();
        apb(1'b1, CONTROL_ADDR, 32'h0000000E);
        pin0 <= 1'b0;
        wait_vec(VEC_EXT0);
        do_ret();
        apb(1'b1, CONTROL_ADDR, 32'h0000000C);
        wait_vec(VEC_EXT0);
        do_ret();
        wait_vec(VEC_EXT0);
        @(posedge pclk);
        pin0 <= 1'b1;
        repeat (4) @(posedge pclk);
        do_ret();
        repeat (20) @(negedge pclk);
        `CHK(global_irq_enable, 1'b1)
    endtask : t_ext

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : finish_test

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // Generous ceiling; the whole run needs a few hundred cycles
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            finish_test();
        end
    end

    initial
    begin
        {presetn, psel, penable, pwrite, paddr, pwdata, evt} = '0;
        {pin0, pin1, slow_mode, ret_req} = 4'hC;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_flags();
        t_vec();
        t_ext();
        finish_test();
    end
endmodule : tb
